// file: hdl/pnf_regs.vh
/*
  register map, field positions, command codes and timing counts of the flash controller.
  assumes a 250 MHz clock and a 32-bit avalon-mm slave window with word addresses.
*/
`ifndef PNF_REGS_VH
`define PNF_REGS_VH
// ****************************************************************
// register word offsets
// ****************************************************************
`define PNF_REG_CTRL     3'h0
`define PNF_REG_ADDR     3'h1
`define PNF_REG_WDATA    3'h2
`define PNF_REG_STATUS   3'h3
`define PNF_REG_RDATA    3'h4
// ****************************************************************
// control fields
// ****************************************************************
`define PNF_CTRL_OP_LSB  0
`define PNF_CTRL_OP_MSB  3
`define PNF_CTRL_WORD    4
`define PNF_CTRL_PDOWN   5
`define PNF_CTRL_WPLOW   6
`define PNF_CTRL_RESET   0
// ****************************************************************
// operation codes written to the control register
// ****************************************************************
`define PNF_OP_NONE      4'h0
`define PNF_OP_READ      4'h1
`define PNF_OP_PROG      4'h2
`define PNF_OP_SECERASE  4'h3
`define PNF_OP_CHIPERASE 4'h4
`define PNF_OP_SUSPEND   4'h5
`define PNF_OP_RESUME    4'h6
`define PNF_OP_BYPENTER  4'h7
`define PNF_OP_BYPPROG   4'h8
`define PNF_OP_BYPEXIT   4'h9
`define PNF_OP_SECENTER  4'hA
`define PNF_OP_SECEXIT   4'hB
`define PNF_OP_RESET     4'hC
// ****************************************************************
// flash command bytes and unlock addresses
// ****************************************************************
`define PNF_UNLOCK_A1    20'h00555
`define PNF_UNLOCK_A2    20'h002AA
`define PNF_UNLOCK_D1    16'h00AA
`define PNF_UNLOCK_D2    16'h0055
`define PNF_CMD_PROG     16'h00A0
`define PNF_CMD_ERASE    16'h0080
`define PNF_CMD_SECTOR   16'h0030
`define PNF_CMD_CHIP     16'h0010
`define PNF_CMD_SUSPEND  16'h00B0
`define PNF_CMD_RESUME   16'h0030
`define PNF_CMD_BYPASS   16'h0020
`define PNF_CMD_BYPEXIT1 16'h0090
`define PNF_CMD_BYPEXIT2 16'h0000
`define PNF_CMD_SECENTER 16'h0088
`define PNF_CMD_SECEXIT1 16'h0090
`define PNF_CMD_SECEXIT2 16'h0000
`define PNF_CMD_RESET    16'h00F0
// ****************************************************************
// bus timing and status bits
// ****************************************************************
`define PNF_ACCESS_CYC   8'h0E // 55 ns at 4 ns a clock, rounded up
`define PNF_RESET_CYC    8'h7D // 500 ns pulse
`define PNF_STAT_DQ7     7
`define PNF_STAT_DQ6     6
`endif

// file: hdl/pnf_cmd_rom.v
/*
  command sequence table: returns address and data of one bus write per step.
  assumes a registered lookup; read data appear one clock after the index.
*/
`timescale 1ns/1ps
`include "pnf_regs.vh"
module pnf_cmd_rom (
  // clock
  input  wire        clock,
  // lookup
  input  wire [3:0]  op,
  input  wire [2:0]  step,
  input  wire [19:0] userAddr,
  input  wire [15:0] userData,
  // result
  output reg  [19:0] cmdAddr,
  output reg  [15:0] cmdData,
  output reg  [2:0]  cmdCount
);
  // ****************************************************************
  // lookup
  // ****************************************************************
  reg [19:0] a;
  reg [15:0] d;
  reg [2:0]  n;
  always @* begin
    a = `PNF_UNLOCK_A1;
    d = `PNF_UNLOCK_D1;
    n = 3'h0;
    case (op)
      `PNF_OP_PROG: begin
        n = 3'h4;
        if (step == 3'h1) begin a = `PNF_UNLOCK_A2; d = `PNF_UNLOCK_D2; end
        if (step == 3'h2) d = `PNF_CMD_PROG;
        if (step == 3'h3) begin a = userAddr; d = userData; end
      end
      `PNF_OP_SECERASE, `PNF_OP_CHIPERASE: begin
        n = 3'h6;
        if (step == 3'h1 || step == 3'h4) begin a = `PNF_UNLOCK_A2; d = `PNF_UNLOCK_D2; end
        if (step == 3'h2) d = `PNF_CMD_ERASE;
        if (step == 3'h5) begin
          a = (op == `PNF_OP_SECERASE) ? userAddr : `PNF_UNLOCK_A1;
          d = (op == `PNF_OP_SECERASE) ? `PNF_CMD_SECTOR : `PNF_CMD_CHIP;
        end
      end
      `PNF_OP_BYPENTER, `PNF_OP_SECENTER: begin
        n = 3'h3;
        if (step == 3'h1) begin a = `PNF_UNLOCK_A2; d = `PNF_UNLOCK_D2; end
        if (step == 3'h2) d = (op == `PNF_OP_BYPENTER) ? `PNF_CMD_BYPASS : `PNF_CMD_SECENTER;
      end
      `PNF_OP_SECEXIT: begin
        n = 3'h4;
        if (step == 3'h1) begin a = `PNF_UNLOCK_A2; d = `PNF_UNLOCK_D2; end
        if (step == 3'h2) d = `PNF_CMD_SECEXIT1;
        if (step == 3'h3) d = `PNF_CMD_SECEXIT2;
      end
      `PNF_OP_BYPPROG: begin
        n = 3'h2;
        d = `PNF_CMD_PROG;
        if (step == 3'h1) begin a = userAddr; d = userData; end
      end
      `PNF_OP_BYPEXIT: begin
        n = 3'h2;
        d = (step == 3'h0) ? `PNF_CMD_BYPEXIT1 : `PNF_CMD_BYPEXIT2;
      end
      `PNF_OP_SUSPEND: begin n = 3'h1; a = userAddr; d = `PNF_CMD_SUSPEND; end
      `PNF_OP_RESUME:  begin n = 3'h1; a = userAddr; d = `PNF_CMD_RESUME; end
      `PNF_OP_RESET:   begin n = 3'h1; d = `PNF_CMD_RESET; end
      default: n = 3'h0;
    endcase
    cmdCount = n; // live: the first step sees the new op
  end
  always @(posedge clock) begin
    cmdAddr  <= a;
    cmdData  <= d;
  end
endmodule // pnf_cmd_rom

// file: hdl/pnf_bus_cycle.v
/*
  one asynchronous flash bus cycle (read or write) built from clock counts.
  assumes the flash needs the access time for both strobe widths.
*/
`timescale 1ns/1ps
`include "pnf_regs.vh"
module pnf_bus_cycle (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // request
  input  wire        start,
  input  wire        isWrite,
  input  wire        wordMode,
  input  wire [19:0] reqAddr,
  input  wire [15:0] reqData,
  output wire        done,
  output reg  [15:0] readData,
  // flash pins
  output reg  [19:0] flashAddr,
  output reg         flashCe_n,
  output reg         flashWe_n,
  output reg         flashOe_n,
  output reg  [15:0] flashDqOut,
  output reg         flashDqOe,
  input  wire [15:0] flashDqIn
);
  // ****************************************************************
  // strobe timing
  // ****************************************************************
  localparam [7:0] ACC = `PNF_ACCESS_CYC;
  reg [7:0] cnt;
  reg       busy;
  reg       wr;
  assign done = busy && (cnt == 8'h00);
  always @(posedge clock) begin
    if (rst) begin
      busy <= 1'b0; cnt <= 8'h00; wr <= 1'b0; flashAddr <= 20'h00000;
      flashCe_n <= 1'b1; flashWe_n <= 1'b1; flashOe_n <= 1'b1;
      flashDqOut <= 16'h0000; flashDqOe <= 1'b0; readData <= 16'h0000;
    end else if (start && !busy) begin
      busy <= 1'b1; cnt <= ACC; wr <= isWrite; flashAddr <= reqAddr;
      flashCe_n <= 1'b0;
      flashWe_n <= ~isWrite;
      flashOe_n <= isWrite;
      flashDqOe <= isWrite;
      flashDqOut <= wordMode ? reqData : {8'h00, reqData[7:0]};
    end else if (busy) begin
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (!wr && cnt == 8'h01)
          readData <= wordMode ? flashDqIn : {8'h00, flashDqIn[7:0]};
      end else begin
        busy <= 1'b0;
        flashCe_n <= 1'b1; flashWe_n <= 1'b1; flashOe_n <= 1'b1;
        flashDqOe <= 1'b0;
      end
    end
  end
endmodule // pnf_bus_cycle

// file: hdl/pnf_flash_ctrl.v
/*
  host-side controller for a parallel nor flash: software orders operations over
  avalon-mm, the block issues command cycles and polls completion.
  assumes the flash pins are synchronous to clock and bus outputs are sampled by pads.
*/
`timescale 1ns/1ps
`include "pnf_regs.vh"
module pnf_flash_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // avalon-mm slave
  input  wire [2:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWritedata,
  output reg  [31:0] avsReaddata,
  output wire        avsWaitrequest,
  // flash pins
  output wire [19:0] flashAddr,
  output wire        flashCe_n,
  output wire        flashWe_n,
  output wire        flashOe_n,
  output wire [15:0] flashDqOut,
  output wire        flashDqOe,
  input  wire [15:0] flashDqIn,
  output reg         flashReset_n,
  output reg         flashWordMode,
  output reg         flashWp_n,
  input  wire        readyBusyOut
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_LOOK  = 6'h02;
  localparam [5:0] S_CYC   = 6'h04;
  localparam [5:0] S_POLL  = 6'h08;
  localparam [5:0] S_CHECK = 6'h10;
  localparam [5:0] S_HWRST = 6'h20;
  localparam [7:0] RST_CYC = `PNF_RESET_CYC;

  reg  [5:0]  state;
  reg  [3:0]  op;
  reg  [2:0]  step;
  reg  [19:0] userAddr;
  reg  [15:0] userData;
  reg  [15:0] rdata;
  reg  [15:0] lastPoll;
  reg         havePoll;
  reg         bypass;
  reg         suspended;
  reg         secure;
  reg         failed;
  reg         powerDown;
  reg         rdAck;
  reg  [7:0]  rcnt;
  reg         cycStart;
  reg         cycWrite;
  wire        cycDone;
  wire [15:0] cycRead;
  wire [19:0] romAddr;
  wire [15:0] romData;
  wire [2:0]  romCount;
  wire        busy = (state != S_IDLE);
  wire        ctrlWr = avsWrite && (avsAddress == `PNF_REG_CTRL);
  wire        newOp = ctrlWr && !busy;

  // ****************************************************************
  // register access
  // ****************************************************************
  // control writes stall while busy; reads take one wait so data come from a flop
  assign avsWaitrequest = (ctrlWr && busy) || (avsRead && !rdAck);
  always @(posedge clock) begin
    if (rst) begin
      userAddr <= 20'h00000; userData <= 16'h0000; flashWordMode <= 1'b1;
      powerDown <= 1'b0; flashWp_n <= 1'b1; avsReaddata <= 32'h00000000; rdAck <= 1'b0;
    end else begin
      if (avsWrite && avsAddress == `PNF_REG_ADDR)  userAddr <= avsWritedata[19:0];
      if (avsWrite && avsAddress == `PNF_REG_WDATA) userData <= avsWritedata[15:0];
      if (newOp) begin
        flashWordMode <= avsWritedata[`PNF_CTRL_WORD];
        powerDown <= avsWritedata[`PNF_CTRL_PDOWN];
        flashWp_n <= ~avsWritedata[`PNF_CTRL_WPLOW];
      end
      rdAck <= avsRead && !rdAck;
      if (avsRead && !rdAck) begin
        case (avsAddress)
          `PNF_REG_CTRL:   avsReaddata <= {25'h0, ~flashWp_n, powerDown, flashWordMode, op};
          `PNF_REG_ADDR:   avsReaddata <= {12'h000, userAddr};
          `PNF_REG_WDATA:  avsReaddata <= {16'h0000, userData};
          `PNF_REG_STATUS: avsReaddata <= {26'h0, readyBusyOut, secure, suspended,
                                           bypass, failed, busy};
          `PNF_REG_RDATA:  avsReaddata <= {16'h0000, rdata};
          default:         avsReaddata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @(posedge clock) begin
    if (rst) begin
      state <= S_IDLE; op <= `PNF_OP_NONE; step <= 3'h0; rdata <= 16'h0000;
      lastPoll <= 16'h0000; havePoll <= 1'b0; bypass <= 1'b0; suspended <= 1'b0;
      secure <= 1'b0; failed <= 1'b0; rcnt <= 8'h00; cycStart <= 1'b0;
      cycWrite <= 1'b0; flashReset_n <= 1'b1;
    end else begin
      cycStart <= 1'b0;
      case (state)
        S_IDLE: begin
          if (newOp) begin
            op <= avsWritedata[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB];
            step <= 3'h0;
            failed <= 1'b0;
            if (avsWritedata[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB] == `PNF_OP_RESET) begin
              flashReset_n <= 1'b0;
              rcnt <= RST_CYC - 8'h01;
              state <= S_HWRST;
            end else if (avsWritedata[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB] == `PNF_OP_READ) begin
              cycWrite <= 1'b0;
              cycStart <= 1'b1;
              state <= S_CYC;
            end else if (avsWritedata[`PNF_CTRL_OP_MSB:`PNF_CTRL_OP_LSB] != `PNF_OP_NONE) begin
              state <= S_LOOK;
            end
          end
        end
        S_LOOK: begin
          if (romCount == 3'h0) begin
            state <= S_IDLE;
          end else begin
            cycWrite <= 1'b1;
            cycStart <= 1'b1;
            state <= S_CYC;
          end
        end
        S_CYC: begin
          if (cycDone) begin
            if (op == `PNF_OP_READ) begin
              rdata <= cycRead;
              state <= S_IDLE;
            end else if (step + 3'h1 < romCount) begin
              step <= step + 3'h1;
              state <= S_LOOK;
            end else begin
              case (op)
                `PNF_OP_BYPENTER: bypass <= 1'b1;
                `PNF_OP_BYPEXIT:  bypass <= 1'b0;
                `PNF_OP_SECENTER: secure <= 1'b1;
                `PNF_OP_SECEXIT:  secure <= 1'b0;
                `PNF_OP_SUSPEND:  suspended <= 1'b1;
                `PNF_OP_RESUME:   suspended <= 1'b0;
                default:          suspended <= suspended;
              endcase
              havePoll <= 1'b0;
              if (op == `PNF_OP_PROG || op == `PNF_OP_BYPPROG || op == `PNF_OP_SECERASE
                  || op == `PNF_OP_CHIPERASE || op == `PNF_OP_RESUME) begin
                state <= S_POLL;
              end else begin
                state <= S_IDLE;
              end
            end
          end
        end
        S_POLL: begin
          cycWrite <= 1'b0;
          cycStart <= 1'b1;
          state <= S_CHECK;
        end
        S_CHECK: begin
          if (cycDone) begin
            // two equal toggle reads with the ready pin high mean done
            if (havePoll && cycRead[`PNF_STAT_DQ6] == lastPoll[`PNF_STAT_DQ6]
                && readyBusyOut) begin
              rdata <= cycRead;
              // program into a protected sector stops toggling without data match
              if (op != `PNF_OP_SECERASE && op != `PNF_OP_CHIPERASE && op != `PNF_OP_RESUME
                  && cycRead[`PNF_STAT_DQ7] != userData[`PNF_STAT_DQ7])
                failed <= 1'b1;
              state <= S_IDLE;
            end else begin
              lastPoll <= cycRead;
              havePoll <= 1'b1;
              state <= S_POLL;
            end
          end
        end
        S_HWRST: begin
          if (rcnt != 8'h00) begin
            rcnt <= rcnt - 8'h01;
          end else begin
            flashReset_n <= 1'b1;
            bypass <= 1'b0; suspended <= 1'b0; secure <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // leaves
  // ****************************************************************
  pnf_cmd_rom uRom (
    .clock    (clock),
    .op       (op),
    .step     (step),
    .userAddr (userAddr),
    .userData (userData),
    .cmdAddr  (romAddr),
    .cmdData  (romData),
    .cmdCount (romCount)
  );

  pnf_bus_cycle uCyc (
    .clock      (clock),
    .rst        (rst),
    .start      (cycStart),
    .isWrite    (cycWrite),
    .wordMode   (flashWordMode),
    .reqAddr    ((state == S_CYC && op != `PNF_OP_READ) ? romAddr : userAddr),
    .reqData    (romData),
    .done       (cycDone),
    .readData   (cycRead),
    .flashAddr  (flashAddr),
    .flashCe_n  (flashCe_n),
    .flashWe_n  (flashWe_n),
    .flashOe_n  (flashOe_n),
    .flashDqOut (flashDqOut),
    .flashDqOe  (flashDqOe),
    .flashDqIn  (flashDqIn)
  );
endmodule // pnf_flash_ctrl

// file: test/pnf_flash_ctrl_assertions.sv
/*
  pin and bus checks on the flash controller.
  assumes one clock domain and the counts of pnf_regs.vh.
*/
`timescale 1ns/1ps
`include "pnf_regs.vh"
module pnf_ctrl_checker (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // avalon-mm
  input wire [2:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsWritedata,
  input wire [31:0] avsReaddata,
  input wire        avsWaitrequest,
  // flash pins
  input wire [19:0] flashAddr,
  input wire        flashCe_n,
  input wire        flashWe_n,
  input wire        flashOe_n,
  input wire [15:0] flashDqOut,
  input wire        flashDqOe,
  input wire [15:0] flashDqIn,
  input wire        flashReset_n,
  input wire        flashWordMode,
  input wire        flashWp_n,
  input wire        readyBusyOut
);
  // ****************************************************************
  // reset pulse length
  // ****************************************************************
  localparam int RESET_CYC = `PNF_RESET_CYC;
  logic [7:0] lowCnt;
  always @(posedge clock) begin
    if (rst || flashReset_n) lowCnt <= 8'h00;
    else lowCnt <= lowCnt + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ****************************************************************
  // properties
  // ****************************************************************
  reset_idle_a: assert property (rst |=> flashCe_n && flashWe_n && flashOe_n && !flashDqOe
    && flashReset_n && flashWordMode && flashWp_n && avsReaddata == 32'h0) else $error("idle pins");
  bus_turn_a: assert property (flashDqOe |-> flashOe_n) else $error("data bus contention");
  strobe_sel_a: assert property ((!flashWe_n || !flashOe_n) |-> !flashCe_n &&
    (flashWe_n || flashOe_n)) else $error("strobe without select");
  write_width_a: assert property ($fell(flashWe_n) |-> (!flashWe_n)[*8] ##1
    (!flashWe_n)[*6] ##[1:2] flashWe_n) else $error("write strobe width");
  latch_stable_a: assert property (!flashWe_n && $past(!flashWe_n) |-> $stable(flashAddr)
    && $stable(flashDqOut) && flashDqOe) else $error("write cycle moved");
  hw_reset_len_a: assert property ($rose(flashReset_n) |-> lowCnt == RESET_CYC)
    else $error("reset pulse length");
  reset_cap_a: assert property (lowCnt <= RESET_CYC) else $error("reset pulse too long");
  wait_cause_a: assert property (avsWaitrequest |-> avsRead
    || avsWrite && avsAddress == `PNF_REG_CTRL) else $error("wait without cause");
  wait_bound_a: assert property (avsWaitrequest |-> ##[1:1000] !avsWaitrequest)
    else $error("wait never ends");
endmodule // pnf_ctrl_checker
bind pnf_flash_ctrl pnf_ctrl_checker u_checker (.clock(clock), .rst(rst),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .flashAddr(flashAddr),
  .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashReset_n(flashReset_n),
  .flashWordMode(flashWordMode), .flashWp_n(flashWp_n), .readyBusyOut(readyBusyOut));

// file: test/pnf_flash_model.sv
/*
  behavioural parallel nor flash: command decoder, timed program and erase, status reads.
  assumes pins are sampled on the controller clock; timers count that clock.
*/
`timescale 1ns/1ps
module pnf_flash_model #(
  parameter logic [6:0]  PROT_SECTOR = 7'h0C,
  parameter logic [15:0] SERIAL_WORD = 16'h5A3C, // arbitrary value
  parameter int          PROG_CYC    = 40,
  parameter int          ERASE_CYC   = 150
) (
  // timer clock
  input wire         clock,
  // flash pins
  input wire  [19:0] flashAddr,
  input wire         flashCe_n,
  input wire         flashWe_n,
  input wire         flashOe_n,
  input wire  [15:0] flashDqOut,
  input wire         flashReset_n,
  input wire         flashWordMode,
  input wire         flashWp_n,
  output logic [15:0] flashDqIn,
  output logic        readyBusyOut,
  // bench side
  input wire          lowSupply,
  output logic [31:0] writeCount
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] q [$];
  logic [19:0] capAddr;
  logic [15:0] capData, tgtData, lastOut, out;
  logic weLow = 0, oeLow = 0, tog = 0, bypass = 0, secure = 0, suspended = 0, chip = 0;
  logic [6:0] eraseSec;
  int step = 0, progCnt = 0, eraseCnt = 0;
  wire reading = !flashCe_n && !flashOe_n;
  function automatic logic [6:0] sec(input logic [19:0] a);
    return {a[19:15], a[19:15] != 0 ? 2'd0 : a[14] ? 2'd3 : a[13] ? 2'd1 + a[12] : 2'd0};
  endfunction
  function automatic logic guarded(input logic [19:0] a);
    return sec(a) == PROT_SECTOR || (!flashWp_n && sec(a) == 7'h00);
  endfunction
  function automatic logic [15:0] arr(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic isBusy();
    return progCnt > 0 || (eraseCnt > 0 && !suspended);
  endfunction
  task automatic command(input logic [19:0] a, input logic [15:0] d);
    logic u1, u2;
    u1 = a[10:0] == 11'h555 && d[7:0] == 8'hAA;
    u2 = a[10:0] == 11'h2AA && d[7:0] == 8'h55;
    writeCount++;
    if (d[7:0] == 8'hF0) step = 0;
    else if (isBusy()) begin
      if (d[7:0] == 8'hB0 && eraseCnt > 0) suspended = 1;
    end else if (suspended && step == 0 && d[7:0] == 8'h30) suspended = 0;
    else case (step)
      0: step = bypass && d[7:0] == 8'hA0 ? 3 : bypass && d[7:0] == 8'h90 ? 8 : u1 ? 1 : 0;
      1: step = u2 ? 2 : 0;
      2: begin
        step = d[7:0] == 8'hA0 ? 3 : d[7:0] == 8'h80 ? 4 : d[7:0] == 8'h90 ? 8 : 0;
        if (d[7:0] == 8'h88) secure = 1;
        if (d[7:0] == 8'h20) bypass = 1;
      end
      3: begin
        step = 0;
        if (!guarded(a) && !(eraseCnt > 0 && sec(a) == eraseSec)) begin
          mem[a] = arr(a) & d;
          tgtData = d;
          progCnt = PROG_CYC;
        end
      end
      4: step = u1 ? 5 : 0;
      5: step = u2 ? 6 : 0;
      6: begin
        step = 0;
        chip = d[7:0] == 8'h10;
        if (chip || (d[7:0] == 8'h30 && !guarded(a))) begin
          eraseSec = sec(a);
          eraseCnt = ERASE_CYC;
        end
      end
      default: begin
        step = 0;
        if (d[7:0] == 8'h00) {secure, bypass} = 2'b00;
      end
    endcase
  endtask
  initial begin
    writeCount = 0;
    lastOut = 16'h0000;
    flashDqIn = 16'hFFFF;
    readyBusyOut = 1'b1;
  end
  always @(posedge clock) begin
    if (!flashReset_n) begin
      {step, progCnt, eraseCnt} = 0;
      {bypass, secure, suspended} = 3'b000;
    end else begin
      if (progCnt > 0) progCnt--;
      if (eraseCnt > 0 && !suspended && --eraseCnt == 0) begin
        q.delete();
        foreach (mem[k]) if (chip ? !guarded(k) : sec(k) == eraseSec) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
      end
      if (weLow && flashWe_n && !lowSupply) command(capAddr, capData);
      if (!oeLow && reading && isBusy()) tog = !tog;
    end
    weLow = !flashWe_n && !flashCe_n;
    if (weLow) {capAddr, capData} = {flashAddr, flashWordMode ? flashDqOut[15:8] : 8'h00,
      flashDqOut[7:0]};
    oeLow = reading;
    if (reading) begin
      if (isBusy()) out = {8'h00, progCnt > 0 ? ~tgtData[7] : 1'b0, tog, 6'h00};
      else if (secure) out = flashAddr[6:0] < 7'h08 ? SERIAL_WORD ^ flashAddr[15:0] : 16'hFFFF;
      else out = arr(flashAddr);
      lastOut = out;
      if (!flashWordMode) out[15:8] = ~out[15:8];
    end else out = ~lastOut;
    flashDqIn <= out;
    readyBusyOut <= !isBusy();
  end
endmodule // pnf_flash_model

// file: test/testbench.sv
/*
  self-checking bench: avalon register tasks drive controller operations against the model.
  assumes the controller answers within the cycle ceiling.
*/
`timescale 1ns/1ps
`include "pnf_regs.vh"
`define CHK(what, exp, got) begin nTests++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module testbench;
  logic        clock, rst, avsRead, avsWrite, lowSupply;
  logic [2:0]  avsAddress;
  logic [31:0] avsWritedata, rd, wc0;
  wire  [31:0] avsReaddata, writeCount;
  wire  [19:0] flashAddr;
  wire  [15:0] flashDqOut, flashDqIn;
  wire         avsWaitrequest, flashCe_n, flashWe_n, flashOe_n, flashDqOe;
  wire         flashReset_n, flashWordMode, flashWp_n, readyBusyOut;
  int          errors = 0, nTests = 0, cycles = 0;
  localparam logic [2:0] W = 3'b001;
  pnf_flash_ctrl u_dut (.clock(clock), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .flashAddr(flashAddr), .flashCe_n(flashCe_n),
    .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn), .flashReset_n(flashReset_n), .flashWordMode(flashWordMode),
    .flashWp_n(flashWp_n), .readyBusyOut(readyBusyOut));
  pnf_flash_model u_flash (.clock(clock), .flashAddr(flashAddr), .flashCe_n(flashCe_n),
    .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashDqOut(flashDqOut),
    .flashReset_n(flashReset_n), .flashWordMode(flashWordMode), .flashWp_n(flashWp_n),
    .flashDqIn(flashDqIn), .readyBusyOut(readyBusyOut), .lowSupply(lowSupply),
    .writeCount(writeCount));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ****************************************************************
  // avalon access and operation tasks
  // ****************************************************************
  task automatic xfer(input logic [2:0] a, input logic wr, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d,
                    input logic [2:0] f);
    xfer(`PNF_REG_ADDR, 1'b1, {12'h000, a});
    xfer(`PNF_REG_WDATA, 1'b1, {16'h0000, d});
    xfer(`PNF_REG_CTRL, 1'b1, {25'h0000000, f, c});
    do xfer(`PNF_REG_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic readArr(input logic [19:0] a, input logic [2:0] f);
    op(`PNF_OP_READ, a, 16'h0000, f);
    xfer(`PNF_REG_RDATA, 1'b0, 32'h0);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      summarize;
    end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {rst, avsRead, avsWrite, lowSupply} = 4'b1000;
    avsAddress = 3'h0;
    avsWritedata = 32'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    xfer(`PNF_REG_STATUS, 1'b0, 32'h0); `CHK("status", 32'h00000020, rd)
    xfer(3'h5, 1'b0, 32'h0); `CHK("unmapped", 32'h00000000, rd)
    op(`PNF_OP_PROG, 20'h08010, 16'h1234, W); readArr(20'h08010, W);
    `CHK("program", 32'h00001234, rd)
    op(`PNF_OP_PROG, 20'h08010, 16'hFF00, W); readArr(20'h08010, W);
    `CHK("clear only", 32'h00001200, rd)
    wc0 = writeCount;
    op(`PNF_OP_PROG, 20'h10020, 16'hBEEF, W); `CHK("program writes", 32'h4, writeCount - wc0)
    op(`PNF_OP_SECERASE, 20'h08010, 16'h0000, W); readArr(20'h08010, W);
    `CHK("erased", 32'h0000FFFF, rd)
    readArr(20'h10020, W); `CHK("other sector", 32'h0000BEEF, rd)
    op(`PNF_OP_PROG, 20'h18000, 16'h0000, W); `CHK("protect flag", 1'b1, rd[1])
    readArr(20'h18000, W); `CHK("protected", 32'h0000FFFF, rd)
    op(`PNF_OP_PROG, 20'h00004, 16'h0000, 3'b101); `CHK("wp pin", 1'b0, flashWp_n)
    `CHK("wp flag", 1'b1, rd[1])
    readArr(20'h00004, W); `CHK("boot sector", 32'h0000FFFF, rd)
    op(`PNF_OP_BYPENTER, 20'h0, 16'h0, W); `CHK("bypass flag", 1'b1, rd[2])
    wc0 = writeCount;
    op(`PNF_OP_BYPPROG, 20'h10030, 16'h00AA, W); `CHK("bypass writes", 32'h2, writeCount - wc0)
    op(`PNF_OP_BYPEXIT, 20'h0, 16'h0, W); `CHK("bypass off", 1'b0, rd[2])
    readArr(20'h10030, W); `CHK("bypass data", 32'h000000AA, rd)
    op(`PNF_OP_SUSPEND, 20'h0, 16'h0, W); `CHK("suspended", 1'b1, rd[3])
    op(`PNF_OP_RESUME, 20'h0, 16'h0, W);
    `CHK("not suspended", 1'b0, rd[3])
    op(`PNF_OP_SECENTER, 20'h0, 16'h0, W); `CHK("secure flag", 1'b1, rd[4])
    readArr(20'h00000, W); `CHK("serial", 32'h00005A3C, rd)
    op(`PNF_OP_SECEXIT, 20'h0, 16'h0, W); `CHK("secure off", 1'b0, rd[4])
    lowSupply <= 1'b1;
    op(`PNF_OP_PROG, 20'h10040, 16'h0000, W); readArr(20'h10040, W);
    `CHK("low supply", 32'h0000FFFF, rd)
    lowSupply <= 1'b0;
    readArr(20'h10020, 3'b000); `CHK("byte lane", 32'hEF, rd)
    `CHK("byte pin", 1'b0, flashWordMode)
    op(`PNF_OP_CHIPERASE, 20'h0, 16'h0, W); readArr(20'h10020, W);
    `CHK("chip erase", 32'h0000FFFF, rd)
    op(`PNF_OP_RESET, 20'h0, 16'h0, W); `CHK("after reset", 32'h00000020, rd)
    summarize;
  end
endmodule // testbench
